// file: rtcu_pkg.sv
// package of constants for the clock update, divider and interrupt control block.
// assumes a 100 MHz system clock and a 32.768 kHz time base arriving on a pin.
package rtcu_pkg;

    // ==================================================
    // register offsets
    localparam logic [7:0] RTCU_RATE_DIVIDER_CTRL_OFS = 8'h0a;
    localparam logic [7:0] RTCU_MODE_CTRL_OFS = 8'h0b;
    localparam logic [7:0] RTCU_IRQ_FLAGS_OFS = 8'h0c;

    // ==================================================
    // field positions
    localparam int RTCU_UPDATE_PENDING_BIT = 7;
    localparam int RTCU_DIV_SEL_LSB = 4;
    localparam int RTCU_RATE_SEL_LSB = 0;
    localparam int RTCU_INHIBIT_BIT = 7;
    localparam int RTCU_PIE_BIT = 6;
    localparam int RTCU_AIE_BIT = 5;
    localparam int RTCU_UIE_BIT = 4;
    localparam int RTCU_DATA_FMT_BIT = 2;
    localparam int RTCU_HOUR_FMT_BIT = 1;
    localparam int RTCU_IRQ_SUMMARY_FLAG_BIT = 7;
    localparam int RTCU_PF_BIT = 6;
    localparam int RTCU_AF_BIT = 5;
    localparam int RTCU_UF_BIT = 4;

    // ==================================================
    // reset values and the normal divider code
    localparam logic [2:0] RTCU_DIV_SEL_RST = 3'h0;
    localparam logic [3:0] RTCU_RATE_SEL_RST = 4'h0;
    localparam logic [2:0] RTCU_DIV_NORMAL = 3'h2;

    // ==================================================
    // divider and timing
    localparam int RTCU_DIV_STAGES = 22;
    localparam logic [21:0] RTCU_DIV_HALF_PRESET = 22'h004000;
    localparam logic [14:0] RTCU_SEC_LAST = 15'h7fff;
    localparam logic [14:0] RTCU_LEAD_TICKS = 15'h0008;
    localparam logic [14:0] RTCU_UIP_START = RTCU_SEC_LAST - RTCU_LEAD_TICKS;
    localparam int RTCU_CLK_MHZ = 100;
    localparam int RTCU_UIP_LEAD_US = 244;
    localparam int RTCU_UPD_CYCLE_US = 1948;
    localparam int RTCU_CNT_W = 18;
    localparam int RTCU_UIP_LEAD_CYC_I = RTCU_UIP_LEAD_US * RTCU_CLK_MHZ;
    localparam int RTCU_UPD_CYCLE_CYC_I = RTCU_UPD_CYCLE_US * RTCU_CLK_MHZ;

    typedef enum logic [1:0] {
        UPD_IDLE,
        UPD_LEAD,
        UPD_BUSY
    } rtcu_upd_state_t;

endpackage : rtcu_pkg

// file: rtcu_ctrl.sv
// update sequencing, divider chain, periodic rate and interrupt flags of the clock.
// assumes time counters outside follow advance_out and present their bytes back here.
//
// Overview of operation
// - one update per second only when inhibit clear and divider not held
// - update advances time with carries, then compares alarm bytes incl. don't-care
// - update-pending rises 244 us before the update begins
// - update cycle lasts 1948 us, measured while update-pending is high
// - the three control and status registers stay accessible at all times
// - setting inhibit aborts an update, blocks new ones, clears update-pending
// - inhibit is read/write and untouched by host reset or internal logic
// - divider select: 010 normal, 000/001/11x held, 011/10x test; host reset keeps
// - leaving a held divider code gives the first update half a second later
// - rate select picks one of 13 taps, or none when zero
// - rate select is read/write and survives host reset
// - periodic enable gates only the interrupt; host reset clears it
// - alarm each matching second gated by alarm enable; host reset clears enable
// - update enable gates only the update interrupt; host reset or inhibit rising clears it
// - data format bit: one binary, zero BCD; survives host reset
// - hour format bit: one 24-hour, zero 12-hour; survives host reset
// - daylight-saving bit and one reserved bit read zero: bits 0 and 3
// - summary flag is any flag with its enable; interrupt pin low then
// - reading the flag register or host reset clears all flags
// - periodic flag sets on the selected tap edge regardless of enable
// - update flag sets at end of every update; read or host reset clears
// - enabling an already set flag asserts the interrupt at once
// - flags stable through a read; events meanwhile posted after it
//
// Chosen here: strobed register access.
`timescale 1ns/100ps
`default_nettype none

module rtcu_ctrl import rtcu_pkg::*; #(
    parameter logic [RTCU_CNT_W-1:0] UIP_LEAD_CYC = RTCU_CNT_W'(RTCU_UIP_LEAD_CYC_I),
    parameter logic [RTCU_CNT_W-1:0] UPD_CYCLE_CYC = RTCU_CNT_W'(RTCU_UPD_CYCLE_CYC_I)
) (
    // clock and reset
    input wire logic clk_sys_in,
    input wire logic resetn_in,
    // pins
    input wire logic osc_32k_in,
    input wire logic host_reset_in,
    output logic irq_out_n_out,
    // register port
    input wire logic [7:0] reg_addr_in,
    input wire logic [7:0] reg_wdata_in,
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    output logic [7:0] reg_rdata_out,
    // time counter link
    output logic advance_out,
    output logic update_pending_out,
    output logic data_format_select_out,
    output logic hour_format_out,
    input wire logic [7:0] time_sec_in,
    input wire logic [7:0] time_min_in,
    input wire logic [7:0] time_hour_in,
    input wire logic [7:0] alarm_sec_in,
    input wire logic [7:0] alarm_min_in,
    input wire logic [7:0] alarm_hour_in
);

    // ==================================================
    // helpers
    function automatic logic div_held(input logic [2:0] sel);
        div_held = (sel == 3'h0) || (sel == 3'h1) || (sel[2:1] == 2'b11);
    endfunction : div_held

    // low-bit mask whose all-ones state ends one period of the selected tap
    function automatic logic [21:0] rate_mask(input logic [3:0] code);
        logic [4:0] n;
        n = 5'(code);
        if (code == 4'h1 || code == 4'h2) begin
            n = 5'(code) + 5'h07;
        end
        rate_mask = (22'h000001 << (n - 5'h01)) - 22'h000001;
    endfunction : rate_mask

    function automatic logic alarm_hit(input logic [7:0] alm, input logic [7:0] tim);
        alarm_hit = (alm[7:6] == 2'b11) || (alm == tim);
    endfunction : alarm_hit

    // ==================================================
    // pin synchronisers
    logic osc_s1_q, osc_s2_q, osc_s3_q;
    logic hrst_s1_q, hrst_s2_q;
    logic tick, host_rst;

    always_ff @(posedge clk_sys_in) begin
        if (!resetn_in) begin
            osc_s1_q <= 1'b0;
            osc_s2_q <= 1'b0;
            osc_s3_q <= 1'b0;
        end else begin
            osc_s1_q <= osc_32k_in;
            osc_s2_q <= osc_s1_q;
            osc_s3_q <= osc_s2_q;
        end
    end

    always_ff @(posedge clk_sys_in) begin
        if (!resetn_in) begin
            hrst_s1_q <= 1'b0;
            hrst_s2_q <= 1'b0;
        end else begin
            hrst_s1_q <= host_reset_in;
            hrst_s2_q <= hrst_s1_q;
        end
    end

    assign tick = osc_s2_q & ~osc_s3_q;
    assign host_rst = hrst_s2_q;

    // ==================================================
    // register decode
    logic wr_a, wr_b, rd_c;
    assign wr_a = reg_wr_in && (reg_addr_in == RTCU_RATE_DIVIDER_CTRL_OFS);
    assign wr_b = reg_wr_in && (reg_addr_in == RTCU_MODE_CTRL_OFS);
    assign rd_c = reg_rd_in && (reg_addr_in == RTCU_IRQ_FLAGS_OFS);

    // ==================================================
    // rate and divider control; host reset deliberately ignored here
    logic [2:0] div_sel_q;
    logic [3:0] rate_sel_q;

    always_ff @(posedge clk_sys_in) begin
        if (!resetn_in) begin
            div_sel_q <= RTCU_DIV_SEL_RST;
            rate_sel_q <= RTCU_RATE_SEL_RST;
        end else if (wr_a) begin
            div_sel_q <= reg_wdata_in[RTCU_DIV_SEL_LSB +: 3];
            rate_sel_q <= reg_wdata_in[RTCU_RATE_SEL_LSB +: 4];
        end
    end

    // ==================================================
    // mode control
    logic inhibit_q, pie_q, aie_q, uie_q, dm_q, h24_q;
    logic inhibit_rise;
    assign inhibit_rise = wr_b && reg_wdata_in[RTCU_INHIBIT_BIT] && !inhibit_q;

    always_ff @(posedge clk_sys_in) begin
        if (!resetn_in) begin
            inhibit_q <= 1'b0;
            dm_q <= 1'b0;
            h24_q <= 1'b0;
        end else if (wr_b) begin
            inhibit_q <= reg_wdata_in[RTCU_INHIBIT_BIT];
            dm_q <= reg_wdata_in[RTCU_DATA_FMT_BIT];
            h24_q <= reg_wdata_in[RTCU_HOUR_FMT_BIT];
        end
    end

    always_ff @(posedge clk_sys_in) begin
        if (!resetn_in || host_rst) begin
            pie_q <= 1'b0;
            aie_q <= 1'b0;
        end else if (wr_b) begin
            pie_q <= reg_wdata_in[RTCU_PIE_BIT];
            aie_q <= reg_wdata_in[RTCU_AIE_BIT];
        end
    end

    always_ff @(posedge clk_sys_in) begin
        if (!resetn_in || host_rst || inhibit_rise) begin
            uie_q <= 1'b0;
        end else if (wr_b) begin
            uie_q <= reg_wdata_in[RTCU_UIE_BIT];
        end
    end

    assign data_format_select_out = dm_q;
    assign hour_format_out = h24_q;

    // ==================================================
    // divider chain; test codes count like normal operation
    logic [RTCU_DIV_STAGES-1:0] div_q;
    logic held;
    assign held = div_held(div_sel_q);

    always_ff @(posedge clk_sys_in) begin
        if (!resetn_in || held) begin
            div_q <= RTCU_DIV_HALF_PRESET;
        end else if (tick) begin
            div_q <= div_q + 22'h000001;
        end
    end

    // ==================================================
    // periodic events
    logic [21:0] pmask;
    logic pf_ev;
    assign pmask = rate_mask(rate_sel_q);
    assign pf_ev = tick && !held && (rate_sel_q != 4'h0) && ((div_q & pmask) == pmask);

    // ==================================================
    // update sequencer; the lead and busy spans run on the system clock so
    // update-pending timing does not depend on the slow time base phase
    rtcu_upd_state_t upd_state_q;
    logic [RTCU_CNT_W-1:0] upd_cnt_q;
    logic advance_q;
    logic upd_end, lead_end;

    assign lead_end = (upd_state_q == UPD_LEAD) && (upd_cnt_q == UIP_LEAD_CYC - 1'b1);
    assign upd_end = (upd_state_q == UPD_BUSY) && (upd_cnt_q == UPD_CYCLE_CYC - 1'b1);

    always_ff @(posedge clk_sys_in) begin
        if (!resetn_in || inhibit_q || held) begin
            upd_state_q <= UPD_IDLE;
            upd_cnt_q <= '0;
        end else begin
            unique case (upd_state_q)
                UPD_IDLE: begin
                    upd_cnt_q <= '0;
                    if (tick && div_q[14:0] == RTCU_UIP_START) begin
                        upd_state_q <= UPD_LEAD;
                    end
                end
                UPD_LEAD: begin
                    upd_cnt_q <= upd_cnt_q + 1'b1;
                    if (lead_end) begin
                        upd_state_q <= UPD_BUSY;
                    end
                end
                UPD_BUSY: begin
                    upd_cnt_q <= upd_cnt_q + 1'b1;
                    if (upd_end) begin
                        upd_state_q <= UPD_IDLE;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge clk_sys_in) begin
        if (!resetn_in || inhibit_q || held) begin
            advance_q <= 1'b0;
        end else begin
            // a write that inhibits or holds in the same cycle cancels the advance
            advance_q <= lead_end && !(wr_b && reg_wdata_in[RTCU_INHIBIT_BIT])
                && !(wr_a && div_held(reg_wdata_in[RTCU_DIV_SEL_LSB +: 3]));
        end
    end

    assign advance_out = advance_q;
    assign update_pending_out = (upd_state_q != UPD_IDLE);

    // alarm compared at the end of the cycle, after the counters have advanced
    logic uf_ev, af_ev;
    assign uf_ev = upd_end && !inhibit_q;
    assign af_ev = uf_ev && alarm_hit(alarm_sec_in, time_sec_in) && alarm_hit(alarm_min_in, time_min_in)
        && alarm_hit(alarm_hour_in, time_hour_in);

    // ==================================================
    // flags; a read clears only what it returned, so new events win
    logic [2:0] flags_q;
    logic [2:0] ev_vec, en_vec;
    logic irq_summary_flag;
    assign ev_vec = {pf_ev, af_ev, uf_ev};
    assign en_vec = {pie_q, aie_q, uie_q};
    assign irq_summary_flag = |(flags_q & en_vec);

    always_ff @(posedge clk_sys_in) begin
        if (!resetn_in || host_rst) begin
            flags_q <= 3'h0;
        end else begin
            flags_q <= (flags_q & ~(rd_c ? flags_q : 3'h0)) | ev_vec;
        end
    end

    assign irq_out_n_out = ~irq_summary_flag;

    // ==================================================
    // read data, valid the cycle after the strobe only
    logic [7:0] rdata_q;

    always_ff @(posedge clk_sys_in) begin
        if (!resetn_in || !reg_rd_in) begin
            rdata_q <= 8'h00;
        end else begin
            unique case (reg_addr_in)
                RTCU_RATE_DIVIDER_CTRL_OFS: rdata_q <= {update_pending_out, div_sel_q, rate_sel_q};
                RTCU_MODE_CTRL_OFS: rdata_q <= {inhibit_q, pie_q, aie_q, uie_q, 1'b0, dm_q, h24_q, 1'b0};
                RTCU_IRQ_FLAGS_OFS: rdata_q <= {irq_summary_flag, flags_q, 4'h0};
                default: rdata_q <= 8'h00;
            endcase
        end
    end

    assign reg_rdata_out = rdata_q;

    // ==================================================
    // checks
    logic [RTCU_CNT_W-1:0] uip_age_q;

    always_ff @(posedge clk_sys_in) begin
        if (!resetn_in || !update_pending_out) begin
            uip_age_q <= '0;
        end else begin
            uip_age_q <= uip_age_q + 1'b1;
        end
    end

    default clocking cb @(posedge clk_sys_in); endclocking
    default disable iff (!resetn_in);

    upd_running_a: assert property (advance_out |-> !inhibit_q && !held)
        else $error("update advanced while inhibited or divider held");
    lead_time_a: assert property (advance_out |-> uip_age_q == UIP_LEAD_CYC)
        else $error("advance not at the lead time after update-pending rose");
    cycle_len_a: assert property (uf_ev |-> uip_age_q == UPD_CYCLE_CYC - 1'b1)
        else $error("update cycle length wrong");
    inhibit_abort_a: assert property (inhibit_q |=> !update_pending_out && !advance_out)
        else $error("update-pending high while inhibited");
    uie_clear_a: assert property (inhibit_rise |=> !uie_q)
        else $error("update enable survived inhibit rising");
    host_rst_a: assert property (host_rst |=> flags_q == 3'h0 && !pie_q && !aie_q && !uie_q)
        else $error("host reset left flags or enables");
    keep_ctrl_a: assert property (host_rst && !reg_wr_in |=> $stable(rate_sel_q) && $stable(div_sel_q)
        && $stable(inhibit_q) && $stable(dm_q) && $stable(h24_q))
        else $error("host reset changed preserved fields");
    read_clear_a: assert property (rd_c && !host_rst |=> (flags_q & $past(flags_q) & ~$past(ev_vec)) == 3'h0)
        else $error("flag survived its read");
    irq_read_a: assert property (rd_c |=> reg_rdata_out[RTCU_IRQ_SUMMARY_FLAG_BIT] == $past(!irq_out_n_out)
        && reg_rdata_out[3:0] == 4'h0)
        else $error("summary flag read disagrees with pin");
    half_sec_a: assert property (!held && $past(held) |-> div_q == RTCU_DIV_HALF_PRESET)
        else $error("divider not preset on leaving hold");
    pf_rate_a: assert property (pf_ev |-> rate_sel_q != 4'h0 && !held)
        else $error("periodic event with no tap selected");

    upd_done_c: cover property (uf_ev ##1 rd_c);
    alarm_c: cover property (af_ev && aie_q);
    periodic_c: cover property (pf_ev && !pie_q);
    abort_c: cover property (update_pending_out ##1 inhibit_q);

endmodule : rtcu_ctrl

`default_nettype wire

// file: test_rtcu_ctrl.sv
// self-checking testbench for the update, divider and interrupt control block.
// assumes rtcu_pkg is compiled first; the bench drives every port itself, no partner model.
`timescale 1ns/100ps
`default_nettype none
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin error_cnt++; \
    $display("MISMATCH t=%0t got %0h exp %0h", $time, (g), (e)); end end

module test_rtcu_ctrl import rtcu_pkg::*;;
    // short counts keep the run well inside the watchdog
    localparam int LEAD = 8;
    localparam int UPD = 40;
    // half a second less the lead, two clocks per time-base tick
    localparam int HALF = (16384 - 8) * 2;
    localparam logic [7:0] RA = RTCU_RATE_DIVIDER_CTRL_OFS;
    localparam logic [7:0] RB = RTCU_MODE_CTRL_OFS;
    localparam logic [7:0] RC = RTCU_IRQ_FLAGS_OFS;
    logic clk_sys_in, resetn_in, osc_32k_in, host_reset_in, reg_wr_in, reg_rd_in;
    logic [7:0] reg_addr_in, reg_wdata_in, reg_rdata_out, ts, tm, th, as_q, am, ah, d, e, p;
    logic irq_out_n_out, advance_out, update_pending_out, data_format_select_out, hour_format_out;
    logic [2:0] mon;
    logic [15:0] lfsr_q;
    logic [2:0] held[4] = '{3'h0, 3'h1, 3'h6, 3'h7};
    logic [3:0] rates[5] = '{4'h3, 4'h4, 4'h1, 4'h8, 4'h5};
    int error_cnt, checks_done, adv_cnt, n, lows;

    rtcu_ctrl #(.UIP_LEAD_CYC(18'(LEAD)), .UPD_CYCLE_CYC(18'(UPD))) dut (
        .clk_sys_in(clk_sys_in), .resetn_in(resetn_in), .osc_32k_in(osc_32k_in),
        .host_reset_in(host_reset_in), .irq_out_n_out(irq_out_n_out), .reg_addr_in(reg_addr_in),
        .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
        .reg_rdata_out(reg_rdata_out), .advance_out(advance_out), .update_pending_out(update_pending_out),
        .data_format_select_out(data_format_select_out), .hour_format_out(hour_format_out),
        .time_sec_in(ts), .time_min_in(tm), .time_hour_in(th),
        .alarm_sec_in(as_q), .alarm_min_in(am), .alarm_hour_in(ah));
    assign mon = {advance_out, update_pending_out, irq_out_n_out};

    // ==================================================
    // clocks and helpers
    initial begin
        clk_sys_in = 1'b0;
        forever #5 clk_sys_in = ~clk_sys_in;
    end
    // time base at half the system clock, free running
    always @(posedge clk_sys_in) osc_32k_in <= (osc_32k_in === 1'b1) ? 1'b0 : 1'b1;
    always @(posedge clk_sys_in) if (advance_out === 1'b1) adv_cnt++;

    function automatic logic [7:0] rnd();
        lfsr_q = {lfsr_q[14:0], lfsr_q[15] ^ lfsr_q[13] ^ lfsr_q[12] ^ lfsr_q[10]};
        return lfsr_q[7:0];
    endfunction : rnd
    // reserved and daylight bits read zero; a rising inhibit drops the update enable
    function automatic logic [7:0] mode_exp(input logic [7:0] v, input logic [7:0] pv);
        logic [7:0] r;
        r = v & 8'hf6;
        if (v[7] && !pv[7]) r[4] = 1'b0;
        return r;
    endfunction : mode_exp
    function automatic int per_exp(input logic [3:0] r);
        return (r < 4'h3) ? (2 << (r + 6)) : (2 << (r - 1));
    endfunction : per_exp

    task automatic idle(input int k);
        repeat (k) @(posedge clk_sys_in);
    endtask : idle
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        reg_addr_in <= a;
        reg_wdata_in <= v;
        reg_wr_in <= 1'b1;
        @(posedge clk_sys_in);
        reg_wr_in <= 1'b0;
        @(posedge clk_sys_in);
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [7:0] v);
        reg_addr_in <= a;
        reg_rd_in <= 1'b1;
        @(posedge clk_sys_in);
        reg_rd_in <= 1'b0;
        @(posedge clk_sys_in);
        v = reg_rdata_out;
    endtask : rd
    task automatic rdc(input logic [7:0] a, input logic [7:0] x);
        logic [7:0] v;
        rd(a, v);
        `CHK(v, x)
    endtask : rdc
    task automatic wait_sig(input int sel, input logic lvl, input int lim, output int k);
        k = 0;
        while (mon[sel] !== lvl && k < lim) begin
            @(posedge clk_sys_in);
            k++;
        end
        if (k >= lim) begin
            error_cnt++;
            $display("MISMATCH t=%0t wait limit on signal %0d", $time, sel);
        end
    endtask : wait_sig
    task automatic end_sim();
        $display("errors %0d checks %0d", error_cnt, checks_done);
        if (error_cnt == 0 && checks_done > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : end_sim

    initial begin
        idle(90000);
        error_cnt++;
        $display("MISMATCH t=%0t watchdog expired", $time);
        end_sim();
    end

    // ==================================================
    // main sequence
    initial begin
        lfsr_q = 16'hf112;
        {resetn_in, host_reset_in, reg_wr_in, reg_rd_in} = 4'h0;
        {reg_addr_in, reg_wdata_in, ts, tm, th, as_q, am, ah} = 64'h0;
        {error_cnt, checks_done, adv_cnt} = 96'h0;
        idle(16);
        resetn_in <= 1'b1;
        idle(1);
        `CHK(irq_out_n_out, 1'b1)
        rdc(RA, 8'h00);
        rdc(RB, 8'h00);
        wr(RC, 8'hff);
        rdc(RC, 8'h00);
        d = rnd();
        rdc({5'h00, d[2:0]}, 8'h00);
        p = 8'h00;
        for (int i = 0; i < 8; i++) begin
            d = rnd();
            e = mode_exp(d, p);
            wr(RB, d);
            rdc(RB, e);
            `CHK({data_format_select_out, hour_format_out}, e[2:1])
            p = e;
            d = rnd();
            wr(RA, d);
            rdc(RA, {1'b0, d[6:0]});
        end
        wr(RB, 8'h00);
        // held divider codes must starve the periodic taps
        for (int i = 0; i < 4; i++) begin
            wr(RA, {1'b0, held[i], 4'h3});
            rd(RC, d);
            idle(40);
            rdc(RC, 8'h00);
        end
        wr(RB, 8'h40);
        for (int i = 0; i < 5; i++) begin
            wr(RA, {4'h2, rates[i]});
            // drop the flag left by the previous rate so the first low is a new tap edge
            rd(RC, d);
            wait_sig(0, 1'b0, 2000, n);
            rdc(RC, 8'hc0);
            wait_sig(0, 1'b0, 2000, n);
            `CHK(n > per_exp(rates[i]) - 8 && n < per_exp(rates[i]) + 4, 1'b1)
        end
        wr(RB, 8'h00);
        rd(RC, d);
        lows = 0;
        repeat (40) begin
            @(posedge clk_sys_in);
            if (irq_out_n_out !== 1'b1) lows++;
        end
        `CHK(lows, 0)
        rdc(RC, 8'h40);
        idle(40);
        wr(RB, 8'h40);
        `CHK(irq_out_n_out, 1'b0)
        wr(RA, 8'h20);
        rd(RC, d);
        idle(300);
        rdc(RC, 8'h00);
        wr(RA, 8'h23);
        idle(20);
        wr(RA, 8'h0f);
        wr(RB, 8'h76);
        wr(RB, 8'hf6);
        rdc(RB, 8'he6);
        host_reset_in <= 1'b1;
        idle(4);
        host_reset_in <= 1'b0;
        idle(4);
        `CHK(irq_out_n_out, 1'b1)
        rdc(RB, 8'h86);
        rdc(RA, 8'h0f);
        rdc(RC, 8'h00);
        // matching seconds and minutes, hour alarm as don't care
        d = rnd();
        ts <= {2'b00, d[5:0]};
        as_q <= {2'b00, d[5:0]};
        d = rnd();
        tm <= {2'b00, d[5:0]};
        am <= {2'b00, d[5:0]};
        th <= {3'b000, d[4:0]};
        ah <= {2'b11, d[5:0]};
        wr(RB, 8'h30);
        wr(RA, 8'h20);
        wait_sig(1, 1'b1, 40000, n);
        `CHK(n > HALF - 12 && n < HALF + 12, 1'b1)
        rdc(RA, 8'ha0);
        wr(RB, 8'hb0);
        idle(2);
        `CHK(update_pending_out, 1'b0)
        idle(60);
        rdc(RC, 8'h00);
        rdc(RB, 8'ha0);
        `CHK(adv_cnt, 0)
        wr(RA, 8'h00);
        wr(RB, 8'h30);
        wr(RA, 8'h40);
        wait_sig(1, 1'b1, 40000, n);
        `CHK(n > HALF - 12 && n < HALF + 12, 1'b1)
        wait_sig(2, 1'b1, 20, n);
        `CHK(n, LEAD)
        wait_sig(1, 1'b0, 100, n);
        `CHK(n, UPD - LEAD)
        `CHK(adv_cnt, 1)
        idle(1);
        `CHK(irq_out_n_out, 1'b0)
        rdc(RC, 8'hb0);
        rdc(RC, 8'h00);
        `CHK(irq_out_n_out, 1'b1)
        end_sim();
    end
endmodule : test_rtcu_ctrl
`default_nettype wire
